// [include/gpqc_map.svh]
// Register offsets, field positions and timing constants of the counter
`ifndef GPQC_MAP_SVH
`define GPQC_MAP_SVH
// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define GQ_OFF_CTRL 8'h00
`define GQ_OFF_STAT 8'h04
`define GQ_OFF_PRE 8'h08
`define GQ_OFF_CMP 8'h0c
`define GQ_OFF_DATA 8'h10
`define GQ_OFF_CMD 8'h14
`define GQ_OFF_DBD 8'h18
`define GQ_OFF_IRQ 8'h1c
// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define GQ_CT_IN 2:0
`define GQ_CT_PS 4:3
`define GQ_CT_QR 6:5
`define GQ_CT_CM 8:7
`define GQ_CT_CTL 11:9
`define GQ_CT_DOWN 12
`define GQ_CT_DB 13
`define GQ_CT_POL 14
`define GQ_CT_CIE 15
`define GQ_CT_MATIE 16
`define GQ_CT_EN 17
`define GQ_CT_MASK 32'h0003ffff
// -----------------------------------------------------------------------------
// Status, command and interrupt control bits
// -----------------------------------------------------------------------------
`define GQ_ST_CEV 0
`define GQ_ST_MAT 1
`define GQ_ST_LAT 2
`define GQ_ST_RUN 3
`define GQ_CMD_LOAD 0
`define GQ_CMD_RST 1
`define GQ_IC_MASTER 0
`define GQ_IC_CEV 1
`define GQ_IC_MAT 2
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define GQ_CLK_MHZ 8'h64
`define GQ_TMR_MHZ 8'h28
`endif

// [include/gpqc_pkg.sv]
// Types of the general purpose quadrature counter
`default_nettype none
package gpqc_pkg;
    typedef enum logic [2:0] {
        GQ_IN_NONE = 3'h0,
        GQ_IN_TMR = 3'h1,
        GQ_IN_DIR = 3'h2,
        GQ_IN_UD = 3'h3,
        GQ_IN_QUAD = 3'h4
    } gpqc_in_e;
    typedef enum logic [2:0] {
        GQ_CTL_NONE = 3'h0,
        GQ_CTL_LOAD = 3'h1,
        GQ_CTL_LATCH = 3'h2,
        GQ_CTL_GATE = 3'h3,
        GQ_CTL_RST = 3'h4
    } gpqc_ctl_e;
    typedef enum logic [1:0] {
        GQ_CM_CYCLE = 2'h0,
        GQ_CM_DIVN = 2'h1,
        GQ_CM_SINGLE = 2'h2
    } gpqc_cm_e;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] pre;
        logic [31:0] cmp;
        logic [15:0] dbdur;
        logic master_irq_enable;
        logic [31:0] cnt;
        logic [31:0] latch;
        logic latched;
        logic running;
        logic f_ctl;
        logic f_match;
        logic [7:0] acc;
        logic l2p;
        logic l3p;
        logic filt;
        logic raw_p;
        logic [15:0] dbc;
        logic act_p;
        logic ack;
        logic [31:0] rdat;
    } gpqc_state_s;
endpackage
`default_nettype wire

// [hw/gpqc_top.sv]
// General purpose counter with timer, count and quadrature inputs
//
// What this block does
// - Timer, direction, up/down, quadrature sources; none disables
// - Changing source keeps the count
// - Timer rate 40, 20, 10, 5 MHz
// - Direction mode: line2 rise, line3 sets direction
// - Up/down lines; simultaneous rises count nothing
// - Quadrature resolution 1x, 2x or 4x
// - Quadrature direction from phase of inputs
// - Cycling by default; all count modes everywhere
// - Divide-by-N reloads preload on carry or borrow
// - Single cycle starts on load or reset
// - Single cycle halts on carry or borrow
// - Control events set flag, interrupt if enabled
// - Bit 14 selects control line polarity
// - Debounce needs stability beyond programmed duration
// - No control mode ignores the line
// - Load edge or command copies preload
// - Latch edge holds count until read/release
// - Gate mode counts while active; close interrupts
// - Reset edge or command clears count
// - Interrupt output needs master enable
// - Per-source enable, write-to-acknowledge flags, summary
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "gpqc_map.svh"
`default_nettype none
module gpqc_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Counter lines
    input wire logic count_a_i,
    input wire logic count_b_i,
    input wire logic control_i,
    // Interrupt request
    output logic local_irq_input_o
);
    gpqc_pkg::gpqc_state_s q;
    gpqc_pkg::gpqc_state_s n;
    gpqc_pkg::gpqc_in_e in_m;
    gpqc_pkg::gpqc_ctl_e ctl_m;
    gpqc_pkg::gpqc_cm_e cnt_m;
    logic acc_st;
    logic acc_wr;
    logic acc_rd;
    logic [7:0] step;
    logic tick;
    logic act;
    logic c_edge;
    logic c_fall;
    logic gate_ok;
    logic cmd_load;
    logic cmd_rst;
    logic ld_ev;
    logic rs_ev;
    logic lt_ev;
    logic cev;
    logic up_r;
    logic dn_r;
    logic xc;
    logic yc;
    logic fwd;
    logic qev;
    logic su;
    logic sd;
    logic go;
    logic wrap;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction

    assign in_m = gpqc_pkg::gpqc_in_e'(q.ctrl[`GQ_CT_IN]);
    assign ctl_m = gpqc_pkg::gpqc_ctl_e'(q.ctrl[`GQ_CT_CTL]);
    assign cnt_m = gpqc_pkg::gpqc_cm_e'(q.ctrl[`GQ_CT_CM]);
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign local_irq_input_o = q.master_irq_enable & ((q.f_ctl & q.ctrl[`GQ_CT_CIE])
        | (q.f_match & q.ctrl[`GQ_CT_MATIE]));

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        n = q;
        // Bus: ack one cycle after the request, write at the acked edge
        acc_st = wb_cyc_i & wb_stb_i & ~q.ack;
        acc_wr = wb_cyc_i & wb_stb_i & q.ack & wb_we_i;
        acc_rd = wb_cyc_i & wb_stb_i & q.ack & ~wb_we_i;
        n.ack = acc_st;
        cmd_load = acc_wr & hit(wb_adr_i, `GQ_OFF_CMD) & wb_sel_i[0] & wb_dat_i[`GQ_CMD_LOAD];
        cmd_rst = acc_wr & hit(wb_adr_i, `GQ_OFF_CMD) & wb_sel_i[0] & wb_dat_i[`GQ_CMD_RST];

        // Timer prescaler as a rate accumulator on the system clock
        step = `GQ_TMR_MHZ >> q.ctrl[`GQ_CT_PS];
        tick = (q.acc + step) >= `GQ_CLK_MHZ;
        n.acc = tick ? 8'(q.acc + step - `GQ_CLK_MHZ) : 8'(q.acc + step);

        // Debounced control line
        n.raw_p = control_i;
        if (!q.ctrl[`GQ_CT_DB]) begin
            n.filt = control_i;
            n.dbc = '0;
        end else if (control_i != q.raw_p || control_i == q.filt) begin
            n.dbc = '0;
        end else if (q.dbc > q.dbdur) begin
            n.filt = control_i;
            n.dbc = '0;
        end else begin
            n.dbc = 16'(q.dbc + 16'h1);
        end
        act = q.filt ^ q.ctrl[`GQ_CT_POL];
        n.act_p = act;
        c_edge = act & ~q.act_p;
        c_fall = ~act & q.act_p;

        // Control mode events; none leaves the line unused
        ld_ev = cmd_load | (ctl_m == gpqc_pkg::GQ_CTL_LOAD & c_edge);
        rs_ev = cmd_rst | (ctl_m == gpqc_pkg::GQ_CTL_RST & c_edge);
        lt_ev = ctl_m == gpqc_pkg::GQ_CTL_LATCH & c_edge;
        gate_ok = ctl_m != gpqc_pkg::GQ_CTL_GATE | act;
        cev = 1'b0;
        unique case (ctl_m)
            gpqc_pkg::GQ_CTL_NONE: cev = 1'b0;
            gpqc_pkg::GQ_CTL_GATE: cev = c_fall;
            gpqc_pkg::GQ_CTL_LOAD, gpqc_pkg::GQ_CTL_LATCH,
            gpqc_pkg::GQ_CTL_RST: cev = c_edge;
            default: cev = 1'b0;
        endcase

        // Input sources
        n.l2p = count_a_i;
        n.l3p = count_b_i;
        up_r = count_a_i & ~q.l2p;
        dn_r = count_b_i & ~q.l3p;
        xc = count_a_i ^ q.l2p;
        yc = count_b_i ^ q.l3p;
        fwd = count_a_i ^ q.l3p;
        unique case (q.ctrl[`GQ_CT_QR])
            2'h0: qev = xc & ~count_b_i;
            2'h1: qev = xc;
            default: qev = xc ^ yc;
        endcase
        su = 1'b0;
        sd = 1'b0;
        unique case (in_m)
            gpqc_pkg::GQ_IN_TMR: begin
                su = tick & ~q.ctrl[`GQ_CT_DOWN];
                sd = tick & q.ctrl[`GQ_CT_DOWN];
            end
            gpqc_pkg::GQ_IN_DIR: begin
                su = up_r & count_b_i;
                sd = up_r & ~count_b_i;
            end
            gpqc_pkg::GQ_IN_UD: begin
                su = up_r & ~dn_r;
                sd = dn_r & ~up_r;
            end
            gpqc_pkg::GQ_IN_QUAD: begin
                su = qev & fwd;
                sd = qev & ~fwd;
            end
            default: begin
                su = 1'b0;
                sd = 1'b0;
            end
        endcase
        go = q.ctrl[`GQ_CT_EN] & in_m != gpqc_pkg::GQ_IN_NONE & gate_ok
            & (cnt_m != gpqc_pkg::GQ_CM_SINGLE | q.running);

        // Counter; the source select never touches the count
        wrap = 1'b0;
        if (rs_ev) begin
            n.cnt = '0;
        end else if (ld_ev) begin
            n.cnt = q.pre;
        end else if (go & su) begin
            n.cnt = q.cnt + 32'h1;
            wrap = &q.cnt;
        end else if (go & sd) begin
            n.cnt = q.cnt - 32'h1;
            wrap = q.cnt == '0;
        end
        if (cnt_m != gpqc_pkg::GQ_CM_SINGLE) begin
            n.running = 1'b0;
        end else if (ld_ev | rs_ev) begin
            n.running = 1'b1;
        end else if (wrap) begin
            n.running = 1'b0;
        end
        if (wrap & cnt_m == gpqc_pkg::GQ_CM_DIVN) begin
            n.cnt = q.pre;
        end

        // Latch: release by data read or status write with bit 2 clear, new latch wins
        if (acc_rd & hit(wb_adr_i, `GQ_OFF_DATA)) begin
            n.latched = 1'b0;
        end
        if (acc_wr & hit(wb_adr_i, `GQ_OFF_STAT) & wb_sel_i[0] & ~wb_dat_i[`GQ_ST_LAT]) begin
            n.latched = 1'b0;
        end
        if (lt_ev) begin
            n.latch = q.cnt;
            n.latched = 1'b1;
        end

        // Flags: write one acknowledges, a new event wins
        if (acc_wr & hit(wb_adr_i, `GQ_OFF_STAT) & wb_sel_i[0]) begin
            n.f_ctl = q.f_ctl & ~wb_dat_i[`GQ_ST_CEV];
            n.f_match = q.f_match & ~wb_dat_i[`GQ_ST_MAT];
        end
        if (cev) begin
            n.f_ctl = 1'b1;
        end
        if (n.cnt == q.cmp && n.cnt != q.cnt) begin
            n.f_match = 1'b1;
        end

        // Register writes
        if (acc_wr) begin
            if (hit(wb_adr_i, `GQ_OFF_CTRL)) begin
                n.ctrl = merge(q.ctrl, wb_dat_i, wb_sel_i) & `GQ_CT_MASK;
            end
            if (hit(wb_adr_i, `GQ_OFF_PRE)) begin
                n.pre = merge(q.pre, wb_dat_i, wb_sel_i);
            end
            if (hit(wb_adr_i, `GQ_OFF_CMP)) begin
                n.cmp = merge(q.cmp, wb_dat_i, wb_sel_i);
            end
            if (hit(wb_adr_i, `GQ_OFF_DBD)) begin
                n.dbdur = 16'(merge({16'h0, q.dbdur}, wb_dat_i, wb_sel_i));
            end
            if (hit(wb_adr_i, `GQ_OFF_IRQ) & wb_sel_i[0]) begin
                n.master_irq_enable = wb_dat_i[`GQ_IC_MASTER];
            end
        end

        // Read data captured as the request is accepted
        if (acc_st) begin
            n.rdat = '0;
            unique case (wb_adr_i)
                `GQ_OFF_CTRL: n.rdat = q.ctrl;
                `GQ_OFF_STAT: begin
                    n.rdat[`GQ_ST_CEV] = q.f_ctl;
                    n.rdat[`GQ_ST_MAT] = q.f_match;
                    n.rdat[`GQ_ST_LAT] = q.latched;
                    n.rdat[`GQ_ST_RUN] = q.running;
                end
                `GQ_OFF_PRE: n.rdat = q.pre;
                `GQ_OFF_CMP: n.rdat = q.cmp;
                `GQ_OFF_DATA: n.rdat = q.latched ? q.latch : q.cnt;
                `GQ_OFF_DBD: n.rdat = {16'h0, q.dbdur};
                `GQ_OFF_IRQ: begin
                    n.rdat[`GQ_IC_MASTER] = q.master_irq_enable;
                    n.rdat[`GQ_IC_CEV] = q.f_ctl & q.ctrl[`GQ_CT_CIE];
                    n.rdat[`GQ_IC_MAT] = q.f_match & q.ctrl[`GQ_CT_MATIE];
                end
                default: n.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence quad_fwd_s;
        in_m == gpqc_pkg::GQ_IN_QUAD && go && up_r && !count_b_i && !yc;
    endsequence
    sequence gate_close_s;
        ctl_m == gpqc_pkg::GQ_CTL_GATE ##1 (ctl_m == gpqc_pkg::GQ_CTL_GATE && c_fall);
    endsequence

    src_off_a: assert property ((in_m == gpqc_pkg::GQ_IN_NONE && !ld_ev && !rs_ev)
        |=> $stable(q.cnt)) else $error("count moved with no source");
    dir_step_a: assert property ((in_m == gpqc_pkg::GQ_IN_DIR && go && up_r)
        |=> q.cnt == ($past(q.cnt) + ($past(count_b_i) ? 32'h1 : 32'hffffffff)) ||
            $past(rs_ev || ld_ev || wrap)) else $error("direction step wrong");
    ud_both_a: assert property ((in_m == gpqc_pkg::GQ_IN_UD && up_r && dn_r)
        |-> !su && !sd) else $error("simultaneous edges counted");
    quad_up_a: assert property (quad_fwd_s |-> su)
        else $error("leading X not counted up");
    divn_load_a: assert property ((cnt_m == gpqc_pkg::GQ_CM_DIVN && wrap && !ld_ev)
        |=> q.cnt == $past(q.pre)) else $error("divide-by-N missed reload");
    single_halt_a: assert property ((cnt_m == gpqc_pkg::GQ_CM_SINGLE && wrap)
        |=> !q.running ##1 !q.running || $past(ld_ev || rs_ev)) else $error("single cycle ran on");
    gate_irq_a: assert property (gate_close_s |=> q.f_ctl)
        else $error("gate close not flagged");
    irq_mask_a: assert property (!q.master_irq_enable |-> !local_irq_input_o)
        else $error("interrupt without master enable");
    latch_hold_a: assert property ((q.latched && !acc_wr && !acc_rd && !lt_ev)
        |=> q.latched && $stable(q.latch)) else $error("latched value lost");
    match_flag_a: assert property ((n.cnt == q.cmp && n.cnt != q.cnt)
        |=> q.f_match) else $error("match not flagged");
    ack_pulse_a: assert property ((wb_cyc_i && wb_stb_i && !q.ack) |=> q.ack ##1 !q.ack)
        else $error("ack not a single cycle");
    single_idle_a: assert property ((cnt_m == gpqc_pkg::GQ_CM_SINGLE && !q.running
        && !ld_ev && !rs_ev) |=> $stable(q.cnt)) else $error("single cycle counted before start");
    ctl_none_a: assert property (ctl_m == gpqc_pkg::GQ_CTL_NONE |=> !$rose(q.f_ctl))
        else $error("control line used with no control mode");
    gate_hold_a: assert property ((ctl_m == gpqc_pkg::GQ_CTL_GATE && !act
        && !ld_ev && !rs_ev) |=> $stable(q.cnt)) else $error("count moved with gate closed");
endmodule
`default_nettype wire

// [testbench/gpqc_line_model.sv]
// Behavioural encoder and switch on the counter lines
`timescale 1ns/10ps
`default_nettype none
module gpqc_line_model (
    // Clock
    input wire logic mclk_i,
    // Count and control lines
    output logic count_a_o,
    output logic count_b_o,
    output logic control_o
);
    initial begin
        count_a_o = 1'b0;
        count_b_o = 1'b0;
        control_o = 1'b0;
    end
    // Set both count lines, hold them h cycles
    task automatic drive(input logic a, input logic b, input int h);
        @(posedge mclk_i);
        count_a_o <= a;
        count_b_o <= b;
        repeat (h - 1) @(posedge mclk_i);
    endtask
    // One full quadrature cycle, X leading when up
    task automatic quad(input logic up);
        drive(up, !up, 2);
        drive(1'b1, 1'b1, 2);
        drive(!up, up, 2);
        drive(1'b0, 1'b0, 2);
    endtask
    // Switch level held h cycles
    task automatic ctl(input logic v, input int h);
        @(posedge mclk_i);
        control_o <= v;
        repeat (h - 1) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Register level testbench of the quadrature counter
`timescale 1ns/10ps
`include "gpqc_map.svh"
`default_nettype none
module tb;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic count_a;
    logic count_b;
    logic control;
    logic local_irq_input_o;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] t0;
    logic [31:0] t1;
    localparam logic [7:0] CT = `GQ_OFF_CTRL;
    localparam logic [7:0] ST = `GQ_OFF_STAT;
    localparam logic [7:0] PR = `GQ_OFF_PRE;
    localparam logic [7:0] DT = `GQ_OFF_DATA;
    localparam logic [7:0] CM = `GQ_OFF_CMD;

    gpqc_top gpqc_top_inst (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .count_a_i(count_a),
        .count_b_i(count_b),
        .control_i(control),
        .local_irq_input_o(local_irq_input_o)
    );
    gpqc_line_model gpqc_line_model_inst (
        .mclk_i(mclk_i),
        .count_a_o(count_a),
        .count_b_o(count_b),
        .control_o(control)
    );

    always #5 mclk_i = ~mclk_i;

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge mclk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        wb(1'b0, a, 32'h0, x);
        check(nm, x, e);
    endtask
    task automatic irq(input logic e);
        @(posedge mclk_i);
        check("irq_out", 32'(local_irq_input_o), 32'(e));
    endtask
    // Count pulses on the first line with direction b
    task automatic p(input int n, input logic b);
        for (int i = 0; i < n; i++) begin
            gpqc_line_model_inst.drive(1'b0, b, 2);
            gpqc_line_model_inst.drive(1'b1, b, 2);
        end
        gpqc_line_model_inst.drive(1'b0, b, 2);
    endtask
    task automatic cl(input logic v, input int h);
        gpqc_line_model_inst.ctl(v, h);
    endtask
    // Control word: source, count mode, control mode, enable plus extras
    function automatic logic [31:0] cfg(input int s, input int m, input int c,
                                        input logic [31:0] x);
        cfg = x | 32'h00020000;
        cfg[`GQ_CT_IN] = 3'(s);
        cfg[`GQ_CT_CM] = 2'(m);
        cfg[`GQ_CT_CTL] = 3'(c);
    endfunction

    initial begin
        #300000;
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        end_sim();
    end

    // -------------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rc("ctrl_rst", CT, 32'h0);
        rc("stat_rst", ST, 32'h0);
        rc("unmapped", 8'h20, 32'h0);
        wr(`GQ_OFF_CMP, 32'h777);
        wr(CT, cfg(2, 0, 0, 32'h0));
        p(3, 1'b1);
        p(1, 1'b0);
        rc("dir_count", DT, 32'h2);
        wr(CT, cfg(0, 0, 0, 32'h0));
        p(2, 1'b1);
        rc("no_source", DT, 32'h2);
        wr(CT, cfg(3, 0, 0, 32'h0));
        gpqc_line_model_inst.drive(1'b1, 1'b0, 2);
        gpqc_line_model_inst.drive(1'b0, 1'b0, 2);
        gpqc_line_model_inst.drive(1'b0, 1'b1, 2);
        gpqc_line_model_inst.drive(1'b0, 1'b0, 2);
        gpqc_line_model_inst.drive(1'b1, 1'b1, 2);
        gpqc_line_model_inst.drive(1'b0, 1'b0, 2);
        rc("updown", DT, 32'h2);
        for (int r = 0; r < 3; r++) begin
            wr(CT, cfg(4, 0, 0, 32'(r) << 5));
            gpqc_line_model_inst.quad(1'b1);
            rc("quad_up", DT, 32'h2 + (32'h1 << r));
            gpqc_line_model_inst.quad(1'b0);
            rc("quad_down", DT, 32'h2);
        end
        wr(PR, 32'h100);
        wr(CT, cfg(2, 0, 1, 32'h0));
        cl(1'b1, 4);
        rc("load_edge", DT, 32'h100);
        rc("ctl_flag", ST, 32'h1);
        wr(ST, 32'h1);
        rc("flag_ack", ST, 32'h0);
        p(1, 1'b1);
        wr(CT, cfg(2, 0, 1, 32'h4000));
        cl(1'b0, 4);
        rc("low_active", DT, 32'h100);
        p(1, 1'b1);
        wr(CM, 32'h1);
        rc("load_cmd", DT, 32'h100);
        wr(CT, cfg(2, 0, 1, 32'h0));
        wr(CM, 32'h2);
        rc("reset_cmd", DT, 32'h0);
        wr(CT, cfg(2, 0, 4, 32'h0));
        p(3, 1'b1);
        cl(1'b1, 4);
        rc("reset_edge", DT, 32'h0);
        cl(1'b0, 4);
        wr(CT, cfg(2, 0, 2, 32'h0));
        wr(ST, 32'h3);
        p(2, 1'b1);
        cl(1'b1, 4);
        p(3, 1'b1);
        rc("latch_stat", ST, 32'h5);
        rc("latched", DT, 32'h2);
        rc("read_release", DT, 32'h5);
        cl(1'b0, 4);
        cl(1'b1, 4);
        p(1, 1'b1);
        wr(ST, 32'h0);
        rc("bit_release", DT, 32'h6);
        cl(1'b0, 4);
        wr(CT, cfg(2, 0, 3, 32'h0));
        wr(ST, 32'h3);
        p(2, 1'b1);
        rc("gate_closed", DT, 32'h6);
        cl(1'b1, 4);
        p(2, 1'b1);
        cl(1'b0, 4);
        rc("gate_open", DT, 32'h8);
        rc("gate_flag", ST, 32'h1);
        wr(`GQ_OFF_DBD, 32'h8);
        wr(CT, cfg(2, 0, 1, 32'h2000));
        cl(1'b1, 4);
        cl(1'b0, 20);
        rc("bounce", DT, 32'h8);
        cl(1'b1, 20);
        cl(1'b0, 20);
        rc("debounced", DT, 32'h100);
        wr(PR, 32'h2);
        wr(CT, cfg(2, 1, 0, 32'h0));
        wr(CM, 32'h1);
        p(4, 1'b0);
        rc("div_n", DT, 32'h1);
        wr(PR, 32'hfffffffe);
        wr(CT, cfg(2, 2, 0, 32'h0));
        p(1, 1'b1);
        rc("single_idle", DT, 32'h1);
        wr(ST, 32'h3);
        wr(CM, 32'h1);
        rc("single_run", ST, 32'h8);
        p(3, 1'b1);
        rc("single_halt", DT, 32'h0);
        rc("single_stop", ST, 32'h0);
        wr(`GQ_OFF_CMP, 32'h3);
        wr(CT, cfg(2, 0, 0, 32'h10000));
        wr(`GQ_OFF_IRQ, 32'h1);
        p(3, 1'b1);
        irq(1'b1);
        rc("summary", `GQ_OFF_IRQ, 32'h5);
        wr(`GQ_OFF_IRQ, 32'h0);
        irq(1'b0);
        wr(`GQ_OFF_IRQ, 32'h1);
        irq(1'b1);
        wr(ST, 32'h2);
        irq(1'b0);
        wr(CT, cfg(2, 0, 1, 32'h8000));
        cl(1'b1, 4);
        irq(1'b1);
        rc("ctl_summary", `GQ_OFF_IRQ, 32'h3);
        wr(ST, 32'h1);
        irq(1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(CT, cfg(1, 0, 0, 32'(s) << 3));
            wb(1'b0, DT, 32'h0, t0);
            repeat (1000) @(posedge mclk_i);
            wb(1'b0, DT, 32'h0, t1);
            check("timer_rate", 32'((t1 - t0) >= (32'd392 >> s) && (t1 - t0) <= (32'd412 >> s)), 32'h1);
        end
        end_sim();
    end
endmodule
`default_nettype wire
